/* src/abpt_pkg.sv */
// Purpose: shared constants and carriers of the byte port transceiver
// Assumes: one 20 MHz system clock, line clocks arrive as plain pins
// Notes: control and status bit positions, counts and pin indices

package abpt_pkg;

   // control word after master reset
   localparam logic [7:0] CR_RESET = 8'h25;

   // control bit positions
   localparam int CR_LABEL_READ = 1;
   localparam int CR_RX_EN = 2;
   localparam int CR_RX_BLOCK = 3;
   localparam int CR_SELF_TEST = 4;
   localparam int CR_PARITY = 5;
   localparam int CR_LABEL_MATCH = 7;

   // status bit positions
   localparam int SR_TX_READY = 0;
   localparam int SR_RX_READY = 1;
   localparam int SR_TX_IDLE = 2;
   localparam int SR_PARITY = 3;
   localparam int SR_OVERWRITE = 4;
   localparam int SR_FRAMING = 5;
   localparam int SR_FIRST = 6;
   localparam int SR_UNDERWRITE = 7;

   // sticky error vector positions
   localparam int ERR_PARITY = 0;
   localparam int ERR_OVERWRITE = 1;
   localparam int ERR_FRAMING = 2;
   localparam int ERR_UNDERWRITE = 3;

   // pin index in the synchroniser
   localparam int PIN_TX_CLK = 0;
   localparam int PIN_RX_CLK = 1;
   localparam int PIN_RX_ZERO = 2;
   localparam int PIN_RX_ONE = 3;
   localparam int PIN_FEATURE = 4;
   localparam int PIN_SEND_EN_N = 5;
   localparam int N_PINS = 6;

   // framing counts in ticks or bits
   localparam int TICKS_PER_BIT = 4;
   localparam int N_LABELS = 8;
   localparam logic [5:0] WORD_BITS = 6'h20;
   localparam logic [5:0] LAST_BIT = 6'h1f;
   localparam logic [3:0] RX_NULL_END = 4'(3 * TICKS_PER_BIT);
   localparam logic [4:0] TX_GAP_END = 5'(4 * TICKS_PER_BIT - 1);
   localparam logic [3:0] LABEL_SEQ = 4'h8;
   localparam logic [2:0] BYTES_WORD = 3'h4;

   // host port, strobes active low
   typedef struct packed {
      logic chip_select_n;
      logic write_strobe_n;
      logic read_strobe_n;
      logic reg_or_data_select;
      logic [7:0] data;
   } abpt_host_s;

   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} abpt_tx_e;

endpackage

/* src/abpt_label_mem.sv */
// Purpose: eight stored labels with registered readback and match flag
// Assumes: writes and compares in the system clock domain
// Notes: match flag lags the compare value by one clock

`timescale 1ns/1ps

module abpt_label_mem import abpt_pkg::*; (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_wr_en,
   input wire logic [2:0] i_waddr,
   input wire logic [7:0] i_wdata,
   input wire logic [2:0] i_raddr,
   input wire logic [7:0] i_cmp,
   output logic [7:0] o_rdata,
   output logic o_hit
);

   typedef struct packed {
      logic [N_LABELS-1:0][7:0] lbl;
      logic [7:0] rdata;
      logic hit;
   } abpt_mem_s;

   abpt_mem_s st;
   abpt_mem_s next_st;

   // store, read out and compare against every label
   always_comb begin
      next_st = st;
      if (i_wr_en) begin
         next_st.lbl[i_waddr] = i_wdata;
      end
      next_st.rdata = st.lbl[i_raddr];
      next_st.hit = 1'b0;
      for (int i = 0; i < N_LABELS; i++) begin
         if (st.lbl[i] == i_cmp) begin
            next_st.hit = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata = st.rdata;
   assign o_hit = st.hit;

endmodule

/* src/abpt_transceiver.sv */
// Purpose: serial word receiver and transmitter behind an 8-bit host port
// Assumes: host strobes are synchronous one-cycle pulses on i_clk
// Notes: line clocks and line pins are sampled, never used as clocks
// Operation
// [R1] each line clock input runs at four times its bit rate
// [R2] byte-at-a-time or whole 32-bit word buffering
// [R3] optional match of received labels against eight loaded labels
// [R4] only the master reset input resets the block
// [R5] error output high while any error is pending
// [R6] transmitter starts a word only while send enable is low
// [R7] idle output low during a transmission
// [R8] word ready high while received data waits for the host
// [R9] load ready high while the host may write transmit data
// [R10] zero and one bits use separate zero and one lines
// [R11] host port works only under chip select; select picks register or data
// [R12] first byte flag raised when first character of a word is captured
// [R13] self test loops transmitter into receiver and uses transmit clock
// [R14] one parity option governs both directions
// [R15] errors: underwrite, parity, overwrite, sequence
// [R16] sequence error: both lines high, short word before three nulls, long word
// [R17] unmatched labels raise no error
// [R18] errors clear on master reset or a status read
// [R19] modes come from feature select pin and control word
// [R20] reset loads control default; first reception waits for a word gap
// [R21] status bits 1, 3, 4, 5, 6 report ready, parity, overwrite, framing, first
// [R22] enabling label match makes the next eight data writes load labels
// [R23] with parity on, bit 32 carries odd parity
// [R24] line side events are synchronised before the host sees them
//
// The address map and the strobed register port are this design's own decisions.

`timescale 1ns/1ps

module abpt_transceiver import abpt_pkg::*; (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire abpt_host_s i_host,
   input wire logic i_tx_clock_4x,
   input wire logic i_rx_clock_4x,
   input wire logic i_rx_zero_line,
   input wire logic i_rx_one_line,
   input wire logic i_hardware_feature_select,
   input wire logic i_send_enable_n,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_error_flag,
   output logic o_tx_idle_n,
   output logic o_rx_word_ready,
   output logic o_tx_load_ready,
   output logic o_tx_zero_line,
   output logic o_tx_one_line,
   output logic o_first_byte_flag
);

   typedef struct packed {
      logic [N_PINS-1:0] s1;
      logic [N_PINS-1:0] s2;
      logic [N_PINS-1:0] s3;
      logic [N_PINS-1:0] pin;
      logic [N_PINS-1:0] pin_q;
      logic [7:0] ctrl;
      logic [3:0] lw_left;
      logic [2:0] lw_ptr;
      logic [3:0] lr_left;
      logic [2:0] lr_ptr;
      logic [3:0] errs;
      logic rx_hi;
      logic [3:0] rx_null;
      logic [5:0] rx_bits;
      logic [31:0] rx_sh;
      logic rx_par;
      logic rx_armed;
      logic rx_bad;
      logic rx_pass;
      logic [1:0] rx_pend;
      logic [31:0] rbuf;
      logic [2:0] rx_left;
      logic [1:0] rd_ptr;
      logic first;
      abpt_tx_e tx_st;
      logic [31:0] tx_buf;
      logic [2:0] tx_cnt;
      logic [31:0] tx_sh;
      logic [5:0] tx_bit;
      logic [1:0] tx_ph;
      logic [4:0] tx_gap;
      logic tx_par;
      logic tx_l0;
      logic tx_l1;
      logic [7:0] data;
      logic data_oe;
      logic err;
      logic idle_n;
      logic rx_rdy;
      logic tx_rdy;
      logic out0;
      logic out1;
      logic first_o;
   } abpt_state_s;

   abpt_state_s st;
   abpt_state_s next_st;

   logic feature;
   logic par_en;
   logic mode32;
   logic lbl_en;
   logic self_test;
   logic tx_tick;
   logic rx_tick;
   logic line0;
   logic line1;
   logic host_wr;
   logic host_rd;
   logic tx_wr;
   logic lbl_wr;
   logic deliver;
   logic [31:0] dval;
   logic [2:0] dcnt;
   logic dfirst;
   logic err_ok;
   logic tx_b;
   logic [2:0] limit;
   logic [7:0] lbl_rdata;
   logic lbl_hit;

   // rising edge of a filtered pin
   function automatic logic rose(input logic [N_PINS-1:0] now, input logic [N_PINS-1:0] was,
                                 input int idx);
      rose = now[idx] & ~was[idx];
   endfunction

   abpt_label_mem u_labels (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_wr_en(lbl_wr),
      .i_waddr(st.lw_ptr),
      .i_wdata(i_host.data),
      .i_raddr(st.lr_ptr),
      .i_cmp(st.rx_sh[31:24]),
      .o_rdata(lbl_rdata),
      .o_hit(lbl_hit)
   );

   always_comb begin
      next_st = st;
      // three-stage sampling; a level counts once stages two and three agree
      next_st.s1 = {i_send_enable_n, i_hardware_feature_select, i_rx_one_line,
                    i_rx_zero_line, i_rx_clock_4x, i_tx_clock_4x}; // R24
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.pin_q = st.pin;
      for (int i = 0; i < N_PINS; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.pin[i] = st.s3[i];
         end
      end

      // mode decode from feature pin and control word
      feature = st.pin[PIN_FEATURE]; // R19
      par_en = feature | st.ctrl[CR_PARITY]; // R14
      mode32 = feature & ~st.ctrl[CR_PARITY]; // R2
      lbl_en = feature & st.ctrl[CR_LABEL_MATCH]; // R3
      self_test = st.ctrl[CR_SELF_TEST];
      tx_tick = rose(st.pin, st.pin_q, PIN_TX_CLK); // R1
      rx_tick = self_test ? tx_tick : rose(st.pin, st.pin_q, PIN_RX_CLK); // R13
      line0 = self_test ? st.tx_l0 : st.pin[PIN_RX_ZERO]; // R13
      line1 = self_test ? st.tx_l1 : st.pin[PIN_RX_ONE]; // R10
      limit = mode32 ? BYTES_WORD : 3'h1;

      // host port decode
      host_wr = ~i_host.chip_select_n & ~i_host.write_strobe_n; // R11
      host_rd = ~i_host.chip_select_n & ~i_host.read_strobe_n; // R11
      tx_wr = 1'b0;
      lbl_wr = 1'b0;
      next_st.data_oe = host_rd;
      if (host_rd && i_host.reg_or_data_select) begin
         next_st.data = {st.errs[ERR_UNDERWRITE], st.first, st.errs[ERR_FRAMING],
                         st.errs[ERR_OVERWRITE], st.errs[ERR_PARITY], st.idle_n,
                         st.rx_rdy, st.tx_rdy}; // R21
         next_st.errs = '0; // R18
      end else if (host_rd) begin
         if (st.lr_left != 4'h0) begin
            next_st.data = lbl_rdata;
            next_st.lr_left = 4'(st.lr_left - 4'h1);
            next_st.lr_ptr = 3'(st.lr_ptr + 3'h1);
         end else begin
            next_st.data = st.rbuf[8 * st.rd_ptr +: 8];
            if (st.rx_left != 3'h0) begin
               next_st.rx_left = 3'(st.rx_left - 3'h1);
               next_st.rd_ptr = 2'(st.rd_ptr + 2'h1);
               if (st.rx_left == 3'h1) begin
                  next_st.first = 1'b0;
               end
            end
         end
      end
      if (host_wr && i_host.reg_or_data_select) begin
         next_st.ctrl = i_host.data;
         if (feature && i_host.data[CR_LABEL_MATCH] && !st.ctrl[CR_LABEL_MATCH]) begin
            next_st.lw_left = LABEL_SEQ; // R22
            next_st.lw_ptr = 3'h0;
         end
         if (feature && i_host.data[CR_LABEL_READ] && !st.ctrl[CR_LABEL_READ]) begin
            next_st.lr_left = LABEL_SEQ;
            next_st.lr_ptr = 3'h0;
         end
      end else if (host_wr) begin
         if (st.lw_left != 4'h0) begin
            lbl_wr = 1'b1; // R22
            next_st.lw_left = 4'(st.lw_left - 4'h1);
            next_st.lw_ptr = 3'(st.lw_ptr + 3'h1);
         end else begin
            tx_wr = 1'b1;
         end
      end

      // receiver: bit capture, word end and sequence checks
      deliver = 1'b0;
      dval = st.rbuf;
      dcnt = 3'h1;
      dfirst = 1'b0;
      err_ok = st.rx_armed & ((st.rx_bits < 6'h08) | st.rx_pass); // R17
      next_st.rx_pend = {st.rx_pend[0], 1'b0};
      if (!st.ctrl[CR_RX_EN]) begin
         next_st.rx_armed = 1'b0;
         next_st.rx_bits = 6'h00;
         next_st.rx_bad = 1'b0;
         next_st.rx_null = 4'h0;
         next_st.rx_par = 1'b0;
         next_st.rx_pass = 1'b1;
      end else if (rx_tick) begin
         next_st.rx_hi = line0 | line1;
         if (line0 & line1) begin
            next_st.rx_bad = 1'b1;
            if (err_ok && !st.rx_bad) begin
               next_st.errs[ERR_FRAMING] = 1'b1; // R16
            end
         end else if ((line0 | line1) && !st.rx_hi && st.rx_armed && !st.rx_bad) begin
            if (st.rx_bits == WORD_BITS) begin
               next_st.rx_bad = 1'b1;
               if (err_ok) begin
                  next_st.errs[ERR_FRAMING] = 1'b1; // R16
               end
            end else begin
               next_st.rx_sh = {line1, st.rx_sh[31:1]};
               next_st.rx_par = st.rx_par ^ line1;
               next_st.rx_bits = 6'(st.rx_bits + 6'h01);
               if (st.rx_bits[2:0] == 3'h7 && st.rx_bits != LAST_BIT &&
                   (!mode32 || st.rx_bits == 6'h07)) begin
                  next_st.rx_pend[0] = 1'b1;
               end
            end
         end
         if (line0 | line1) begin
            next_st.rx_null = 4'h0;
         end else if (st.rx_null != RX_NULL_END) begin
            next_st.rx_null = 4'(st.rx_null + 4'h1);
            if (next_st.rx_null == RX_NULL_END) begin
               next_st.rx_armed = 1'b1; // R20
               if (st.rx_armed && st.rx_bits != 6'h00 && !st.rx_bad) begin
                  if (st.rx_bits != WORD_BITS) begin
                     if (err_ok) begin
                        next_st.errs[ERR_FRAMING] = 1'b1; // R16
                     end
                  end else if (st.rx_pass) begin
                     if (par_en && !st.rx_par) begin
                        next_st.errs[ERR_PARITY] = 1'b1; // R15
                     end else if (!st.ctrl[CR_RX_BLOCK]) begin
                        deliver = 1'b1;
                        dval = mode32 ? st.rx_sh : {24'h000000, st.rx_sh[31:24]};
                        dcnt = mode32 ? BYTES_WORD : 3'h1;
                        dfirst = mode32;
                     end
                     next_st.ctrl[CR_RX_BLOCK] = 1'b0;
                  end
               end
               next_st.rx_bits = 6'h00;
               next_st.rx_par = 1'b0;
               next_st.rx_bad = 1'b0;
               next_st.rx_pass = 1'b1;
            end
         end
      end
      // byte boundary, two clocks after the shift so the label match has settled
      if (st.rx_pend[1] && !st.rx_bad) begin
         if (st.rx_bits == 6'h08) begin
            next_st.rx_pass = ~lbl_en | lbl_hit; // R3
         end
         if (!mode32 && (st.rx_bits != 6'h08 || !lbl_en || lbl_hit) && st.rx_pass &&
             !st.ctrl[CR_RX_BLOCK]) begin
            deliver = 1'b1; // R2
            dval = {24'h000000, st.rx_sh[31:24]};
            dcnt = 3'h1;
            dfirst = st.rx_bits == 6'h08;
         end
      end
      // hand a byte or word to the host buffer
      if (deliver) begin
         if (st.rx_left != 3'h0) begin
            next_st.errs[ERR_OVERWRITE] = 1'b1; // R15
         end
         next_st.rbuf = dval;
         next_st.rx_left = dcnt;
         next_st.rd_ptr = 2'h0;
         next_st.first = dfirst; // R12
      end

      // transmitter: return-to-zero bits, four ticks each, then a gap
      tx_b = (par_en && st.tx_bit == LAST_BIT) ? ~st.tx_par : st.tx_sh[0]; // R23
      case (st.tx_st)
         TX_IDLE: begin
            next_st.tx_l0 = 1'b0;
            next_st.tx_l1 = 1'b0;
            if (tx_tick && !st.pin[PIN_SEND_EN_N] &&
                (mode32 ? st.tx_cnt == BYTES_WORD : st.tx_cnt != 3'h0)) begin // R6
               next_st.tx_sh = mode32 ? st.tx_buf : {24'h000000, st.tx_buf[7:0]};
               next_st.tx_cnt = 3'h0;
               next_st.tx_bit = 6'h00;
               next_st.tx_ph = 2'h0;
               next_st.tx_par = 1'b0;
               next_st.tx_st = TX_SEND;
            end
         end
         TX_SEND: begin
            if (tx_tick) begin
               next_st.tx_ph = 2'(st.tx_ph + 2'h1);
               if (st.tx_ph == 2'h0) begin
                  next_st.tx_l0 = ~tx_b; // R10
                  next_st.tx_l1 = tx_b; // R10
               end else if (st.tx_ph == 2'h2) begin
                  next_st.tx_l0 = 1'b0;
                  next_st.tx_l1 = 1'b0;
               end else if (st.tx_ph == 2'h3) begin
                  next_st.tx_sh = {1'b0, st.tx_sh[31:1]};
                  next_st.tx_par = st.tx_par ^ tx_b;
                  next_st.tx_bit = 6'(st.tx_bit + 6'h01);
                  if (st.tx_bit == LAST_BIT) begin
                     next_st.tx_gap = 5'h00;
                     next_st.tx_st = TX_GAP;
                  end else if (!mode32 && st.tx_bit[2:0] == 3'h7) begin
                     if (st.tx_cnt != 3'h0) begin
                        next_st.tx_sh[7:0] = st.tx_buf[7:0];
                        next_st.tx_cnt = 3'h0;
                     end else begin
                        next_st.errs[ERR_UNDERWRITE] = 1'b1; // R15
                        next_st.tx_gap = 5'h00;
                        next_st.tx_st = TX_GAP;
                     end
                  end
               end
            end
         end
         TX_GAP: begin
            next_st.tx_l0 = 1'b0;
            next_st.tx_l1 = 1'b0;
            if (tx_tick) begin
               next_st.tx_gap = 5'(st.tx_gap + 5'h01);
               if (st.tx_gap == TX_GAP_END) begin
                  next_st.tx_st = TX_IDLE;
               end
            end
         end
         default: begin
            next_st.tx_st = TX_IDLE;
         end
      endcase
      // host load into the transmit buffer, after any consumption above
      if (tx_wr && next_st.tx_cnt < limit) begin
         next_st.tx_buf[8 * next_st.tx_cnt[1:0] +: 8] = i_host.data;
         next_st.tx_cnt = 3'(next_st.tx_cnt + 3'h1);
      end

      // registered outputs
      next_st.err = |next_st.errs; // R5
      next_st.idle_n = next_st.tx_st == TX_IDLE; // R7
      next_st.rx_rdy = next_st.rx_left != 3'h0; // R8
      next_st.tx_rdy = next_st.tx_cnt < limit; // R9
      next_st.out0 = next_st.tx_l0 & ~self_test; // R13
      next_st.out1 = next_st.tx_l1 & ~self_test; // R13
      next_st.first_o = next_st.first;
   end

   // master reset pin is the only reset source
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0; // R4
         st.ctrl <= CR_RESET; // R20
         st.rx_pass <= 1'b1;
         st.tx_st <= TX_IDLE;
         st.idle_n <= 1'b1;
         st.tx_rdy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign o_data = st.data;
   assign o_data_oe = st.data_oe;
   assign o_error_flag = st.err;
   assign o_tx_idle_n = st.idle_n;
   assign o_rx_word_ready = st.rx_rdy;
   assign o_tx_load_ready = st.tx_rdy;
   assign o_tx_zero_line = st.out0;
   assign o_tx_one_line = st.out1;
   assign o_first_byte_flag = st.first_o;

endmodule

/* test/abpt_line_model.sv */
// Purpose: line side partner making both 4x clocks and serial words
// Assumes: both line clocks are derived from the system clock
// Notes: null is both lines low; words collected lsb first
`timescale 1ns/1ps
module abpt_line_model (
   input wire logic i_clk,
   input wire logic i_tx_zero_line,
   input wire logic i_tx_one_line,
   output logic o_tx_clk,
   output logic o_rx_clk,
   output logic o_rx_zero_line = 1'b0,
   output logic o_rx_one_line = 1'b0
);
   logic [3:0] tx_cnt = 4'h0;
   logic [2:0] rx_cnt = 3'h0;
   logic [4:0] bit_cnt = 5'h00;
   logic [31:0] shift = 32'h0;
   logic [31:0] got = 32'h0;
   int got_num = 0;
   logic prev_zero = 1'b0;
   logic prev_one = 1'b0;
   // 4x clocks of 10 and 8 cycles
   always @(posedge i_clk) begin
      tx_cnt <= (tx_cnt == 4'h9) ? 4'h0 : tx_cnt + 4'h1;
      rx_cnt <= rx_cnt + 3'h1;
   end
   assign o_tx_clk = (tx_cnt > 4'h4);
   assign o_rx_clk = rx_cnt[2];
   // one bit per rising line
   always @(posedge i_clk) begin
      prev_zero <= i_tx_zero_line;
      prev_one <= i_tx_one_line;
      if ((i_tx_zero_line && !prev_zero) || (i_tx_one_line && !prev_one)) begin
         shift <= {i_tx_one_line, shift[31:1]};
         bit_cnt <= bit_cnt + 5'h01;
         if (bit_cnt == 5'h1f) begin
            got <= {i_tx_one_line, shift[31:1]};
            got_num <= got_num + 1;
         end
      end
   end
   // n bits lsb first, 2 ticks high, 2 null; clash drives both
   task automatic send_word(input logic [31:0] w, input int n, input logic clash);
      repeat (16) @(negedge o_rx_clk);
      for (int i = 0; i < n; i++) begin
         o_rx_zero_line <= clash | ~w[i % 32];
         o_rx_one_line <= clash | w[i % 32];
         repeat (2) @(negedge o_rx_clk);
         o_rx_zero_line <= 1'b0;
         o_rx_one_line <= 1'b0;
         repeat (2) @(negedge o_rx_clk);
      end
      repeat (16) @(negedge o_rx_clk);
   endtask
endmodule

/* test/abpt_transceiver_properties.sv */
// Purpose: port checks of the transceiver
// Assumes: one clock domain, reset active high
// Notes: bound to the transceiver
`timescale 1ns/1ps
module abpt_props import abpt_pkg::*; (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire abpt_host_s i_host,
   input wire logic i_send_enable_n,
   input wire logic [7:0] o_data,
   input wire logic o_data_oe,
   input wire logic o_error_flag,
   input wire logic o_tx_idle_n,
   input wire logic o_tx_load_ready,
   input wire logic o_tx_zero_line,
   input wire logic o_tx_one_line
);
   logic rd;
   logic st;
   logic [3:0] en_age;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // read decodes
   assign rd = !i_host.chip_select_n && !i_host.read_strobe_n;
   assign st = rd && i_host.reg_or_data_select;
   // cycles since send enable low
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         en_age <= 4'hf;
      end else if (!i_send_enable_n) begin
         en_age <= 4'h0;
      end else if (en_age != 4'hf) begin
         en_age <= en_age + 4'h1;
      end
   end
   chk_read_answer: assert property (rd |=> o_data_oe)
      else $error("no read data");
   chk_oe_cause: assert property (o_data_oe |-> $past(rd))
      else $error("stray data enable");
   chk_data_hold: assert property (!rd |=> $stable(o_data))
      else $error("data moved");
   chk_error_sticky: assert property (o_error_flag && !st |=> o_error_flag)
      else $error("error flag fell");
   chk_lines_apart: assert property (!(o_tx_zero_line && o_tx_one_line))
      else $error("both lines high");
   chk_idle_quiet: assert property (o_tx_idle_n |-> !o_tx_zero_line && !o_tx_one_line)
      else $error("line active while idle");
   chk_start_gated: assert property ($fell(o_tx_idle_n) |-> en_age < 4'hc)
      else $error("start without enable");
   chk_reset_state: assert property ($fell(i_sys_rst) |->
      o_tx_idle_n && o_tx_load_ready && !o_error_flag && !o_data_oe)
      else $error("bad reset state");
endmodule
bind abpt_transceiver abpt_props i_abpt_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_host(i_host), .i_send_enable_n(i_send_enable_n), .o_data(o_data),
   .o_data_oe(o_data_oe), .o_error_flag(o_error_flag), .o_tx_idle_n(o_tx_idle_n),
   .o_tx_load_ready(o_tx_load_ready), .o_tx_zero_line(o_tx_zero_line),
   .o_tx_one_line(o_tx_one_line));

/* test/abpt_transceiver_test.sv */
// Purpose: self-checking bench of the byte port transceiver
// Assumes: feature pin high, line partner supplies clocks and words
// Notes: random words from a fixed seed
`timescale 1ns/1ps
module abpt_transceiver_test import abpt_pkg::*; ();
   localparam abpt_host_s HOST_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
   logic clk = 1'b0;
   logic rst = 1'b1;
   abpt_host_s host = HOST_IDLE;
   logic feat = 1'b1;
   logic send_n = 1'b1;
   logic tx_clk, rx_clk, rx0, rx1, oe, err, idle_n, rx_rdy, ld_rdy, tx0, tx1, first;
   logic [7:0] dout;
   int err_count = 0;
   int num_checks = 0;
   always #25 clk = ~clk;
   abpt_transceiver i_abpt_transceiver (.i_clk(clk), .i_sys_rst(rst), .i_host(host),
      .i_tx_clock_4x(tx_clk), .i_rx_clock_4x(rx_clk), .i_rx_zero_line(rx0),
      .i_rx_one_line(rx1), .i_hardware_feature_select(feat), .i_send_enable_n(send_n),
      .o_data(dout), .o_data_oe(oe), .o_error_flag(err), .o_tx_idle_n(idle_n),
      .o_rx_word_ready(rx_rdy), .o_tx_load_ready(ld_rdy), .o_tx_zero_line(tx0),
      .o_tx_one_line(tx1), .o_first_byte_flag(first));
   abpt_line_model i_abpt_line_model (.i_clk(clk), .i_tx_zero_line(tx0),
      .i_tx_one_line(tx1), .o_tx_clk(tx_clk), .o_rx_clk(rx_clk),
      .o_rx_zero_line(rx0), .o_rx_one_line(rx1));
   // closing report
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // compare seen against expected
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // word with odd parity in bit 31
   function automatic logic [31:0] odd(input logic [31:0] w);
      return {~^w[30:0], w[30:0]};
   endfunction
   // one-cycle host write
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge clk);
      host <= '{1'b0, 1'b0, 1'b1, sel, d};
      @(posedge clk);
      host <= HOST_IDLE;
      #1;
   endtask
   // host read, data taken next cycle
   task automatic rd(input logic sel, output logic [7:0] d);
      @(posedge clk);
      host <= '{1'b0, 1'b1, 1'b0, sel, 8'h00};
      @(posedge clk);
      host <= HOST_IDLE;
      #1;
      chk(oe, 1'b1);
      d = dout;
   endtask
   // four data accesses, byte 0 first
   task automatic wr_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++) wr(1'b0, w[i*8 +: 8]);
   endtask
   task automatic rd_word(output logic [31:0] w);
      for (int i = 0; i < 4; i++) rd(1'b0, w[i*8 +: 8]);
   endtask
   task automatic snd(input logic [31:0] w, input int n, input logic c);
      i_abpt_line_model.send_word(w, n, c);
   endtask
   // flag, status error bits, then cleared flag
   task automatic expect_err(input logic [7:0] bits);
      logic [7:0] st;
      chk(err, 1'b1);
      rd(1'b1, st);
      chk(st & 8'hb8, bits);
      chk(err, 1'b0);
   endtask
   // bounded wait on idle output
   task automatic wait_idle(input logic v);
      for (int i = 0; i < 5000; i++) begin
         if (idle_n === v) return;
         @(posedge clk);
      end
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      print_verdict();
   endtask
   initial begin
      logic [31:0] w, r;
      logic [7:0] st, base;
      int n;
      void'($urandom(32'hb02f2078));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // defaults, and a read without chip select
      rd(1'b1, st);
      chk(st, 8'h05);
      @(posedge clk);
      host <= '{1'b1, 1'b1, 1'b0, 1'b1, 8'h00};
      @(posedge clk);
      host <= HOST_IDLE;
      #1;
      chk(oe, 1'b0);
      $display("test reset done");
      // word receive, then parity, sequence and overwrite errors
      wr(1'b1, 8'h04);
      w = odd($urandom);
      snd(w, 32, 1'b0);
      chk(rx_rdy, 1'b1);
      chk(first, 1'b1);
      rd_word(r);
      chk(r, w);
      chk(rx_rdy, 1'b0);
      snd(w ^ 32'h80000000, 32, 1'b0);
      chk(rx_rdy, 1'b0);
      expect_err(8'h08);
      snd(w, 33, 1'b0);
      expect_err(8'h20);
      snd(w, 20, 1'b0);
      expect_err(8'h20);
      snd(w, 32, 1'b1);
      expect_err(8'h20);
      snd(w, 32, 1'b0);
      w = odd($urandom);
      snd(w, 32, 1'b0);
      expect_err(8'h10);
      rd_word(r);
      chk(r, w);
      $display("test receive done");
      // transmit held until send enable, parity generated
      w = $urandom;
      wr_word(w);
      chk(ld_rdy, 1'b0);
      repeat (200) @(posedge clk);
      chk(idle_n, 1'b1);
      send_n <= 1'b0;
      wait_idle(1'b0);
      send_n <= 1'b1;
      repeat (500) @(posedge clk);
      chk(idle_n, 1'b0);
      wait_idle(1'b1);
      chk(i_abpt_line_model.got, odd(w));
      chk(ld_rdy, 1'b1);
      $display("test transmit done");
      // self test loop with noise on the external inputs
      wr(1'b1, 8'h14);
      n = i_abpt_line_model.got_num;
      w = $urandom;
      wr_word(w);
      fork
         snd(~w, 32, 1'b1);
      join_none
      send_n <= 1'b0;
      wait_idle(1'b0);
      send_n <= 1'b1;
      wait_idle(1'b1);
      chk(err, 1'b0);
      chk(i_abpt_line_model.got_num, n);
      rd_word(r);
      chk(r, odd(w));
      $display("test self done");
      // label load, unmatched then matched word
      wr(1'b1, 8'h84);
      base = $urandom;
      for (int i = 0; i < 8; i++) wr(1'b0, base + 8'(i));
      w = $urandom;
      w[7:0] = base + 8'h08;
      snd(odd(w), 32, 1'b0);
      chk(rx_rdy, 1'b0);
      chk(err, 1'b0);
      w[7:0] = base + 8'h03;
      snd(odd(w), 32, 1'b0);
      rd_word(r);
      chk(r, odd(w));
      $display("test label done");
      // second reset in mid-run
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(1'b1, st);
      chk(st, 8'h05);
      $display("test rereset done");
      print_verdict();
   end
endmodule
